// ===== bench/aet_trig_src.sv
// external trigger source model that drives the trigger pad
`timescale 1ns/1ps
module aet_trig_src (
  input wire logic clk_sys,
  input wire logic pol,
  input wire logic go,
  input wire logic [7:0] width,
  output logic trig
);
  logic [7:0] left_reg = 8'h00;
  // push-pull pad, rests at the inactive level so a mode change sees no edge
  always @(posedge clk_sys)
  begin
    if (go)
      left_reg <= width;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end
  assign trig = (left_reg != 8'h00) ? pol : ~pol;
endmodule

// ===== bench/aet_trigger_ctrl_bench.sv
// self-checking bench for the adc external trigger control
`timescale 1ns/1ps
module aet_trigger_ctrl_bench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic ce = 1'b1;
  logic [6:0] pads_lo = 7'h00;
  logic src_pol = 1'b1;
  logic go = 1'b0;
  logic [7:0] width = 8'h00;
  logic trig, trig_d, conv_start, conv_busy, seq_done, trig_overrun;
  logic [15:0] rdata;
  logic [7:0] dig_buf_en;
  logic [15:0] exp_q[$];
  logic [31:0] r1, r2;
  int cyc = 0, starts = 0, dones = 0, busys = 0, total = 0, t_edge = 0, t_start = 0, n = 0;
  int bad_count = 0, n_tests = 0;

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  aet_trig_src u_aet_trig_src (.clk_sys(clk_sys), .pol(src_pol), .go(go), .width(width), .trig(trig));
  aet_trigger_ctrl u_aet_trigger_ctrl (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pad_in({trig, pads_lo}), .dig_buf_en(dig_buf_en),
    .conv_start(conv_start), .conv_busy(conv_busy), .seq_done(seq_done), .trig_overrun(trig_overrun));

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ok(input bit c);
    check({15'h0000, c}, 16'h0001);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // the expected word is queued here and consumed by the watcher
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] w);
    @(posedge clk_sys);
    go <= 1'b1;
    width <= w;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic clr;
    idle(1);
    starts = 0;
    dones = 0;
    busys = 0;
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    rd_d <= rd;
    trig_d <= trig;
    if (rd_d === 1'b1)
      check(rdata, exp_q.pop_front());
    if (trig !== trig_d && trig === src_pol)
      t_edge = cyc;
    if (conv_start === 1'b1)
    begin
      starts++;
      total++;
      t_start = cyc;
    end
    if (seq_done === 1'b1)
      dones++;
    if (conv_busy === 1'b1)
      busys++;
    // bounds a hang; the whole run needs well under a thousand cycles
    if (cyc > 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    r1 = $urandom(32'h5f792e3a);
    idle(16);
    rstn <= 1'b1;
    rd_chk(aet_pkg::ADDR_CTRL, 16'h0000);
    rd_chk(aet_pkg::ADDR_DIBE, 16'h0000);
    rd_chk(aet_pkg::ADDR_SEQLEN, 16'h000F);
    rd_chk(aet_pkg::ADDR_STATUS, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    wr_reg(aet_pkg::ADDR_DIBE, 16'h0080);
    wr_reg(aet_pkg::ADDR_SEQLEN, 16'h0003);
    clr();
    wr_reg(aet_pkg::ADDR_START, 16'h0000);
    pulse(8'h02);
    idle(30);
    ok(starts == 1 && dones == 1 && busys == 4);
    clr();
    wr_reg(aet_pkg::ADDR_CTRL, 16'h0008);
    wr_reg(aet_pkg::ADDR_START, 16'h0000);
    pulse(8'h02);
    idle(40);
    ok(starts >= 6);
    wr_reg(aet_pkg::ADDR_CTRL, 16'h0000);
    wr_reg(aet_pkg::ADDR_START, 16'h0000);
    idle(10);
    for (int p = 0; p < 2; p++)
    begin
      // trigger off first, or the polarity flip is itself an edge
      wr_reg(aet_pkg::ADDR_CTRL, 16'h0000);
      @(posedge clk_sys);
      src_pol <= p[0];
      idle(4);
      clr();
      wr_reg(aet_pkg::ADDR_CTRL, {14'h0000, p[0], 1'b1});
      wr_reg(aet_pkg::ADDR_START, 16'h0000);
      idle(10);
      ok(starts == 0);
      rd_chk(aet_pkg::ADDR_STATUS, {12'h000, ~p[0], 3'b010});
      pulse(8'h02);
      idle(20);
      ok(starts == 1 && dones == 1);
      ok(t_start - t_edge >= 2 && t_start - t_edge <= 5);
    end
    wr_reg(aet_pkg::ADDR_SEQLEN, 16'h000F);
    clr();
    pulse(8'h02);
    idle(8);
    pulse(8'h02);
    idle(30);
    ok(starts == 1);
    check({15'h0000, trig_overrun}, 16'h0001);
    wr_reg(aet_pkg::ADDR_STATUS, 16'h0004);
    idle(2);
    check({15'h0000, trig_overrun}, 16'h0000);
    wr_reg(aet_pkg::ADDR_CTRL, 16'h0007);
    wr_reg(aet_pkg::ADDR_START, 16'h0000);
    clr();
    pulse(8'h06);
    idle(8);
    pulse(8'h28);
    idle(60);
    check({15'h0000, trig_overrun}, 16'h0000);
    ok(starts >= 3);
    n = starts;
    idle(40);
    ok(starts == n);
    for (int i = 0; i < 4; i++)
    begin
      r1 = $urandom;
      r2 = $urandom;
      wr_reg(aet_pkg::ADDR_DIBE, r1[15:0]);
      @(posedge clk_sys);
      pads_lo <= r2[6:0];
      idle(4);
      check({8'h00, dig_buf_en}, {8'h00, r1[7:0]});
      rd_chk(aet_pkg::ADDR_PORT, {8'h00, {trig, r2[6:0]} & r1[7:0]});
    end
    @(posedge clk_sys);
    ce <= 1'b0;
    wr_reg(aet_pkg::ADDR_DIBE, 16'h00FF);
    @(posedge clk_sys);
    ce <= 1'b1;
    idle(1);
    check({8'h00, dig_buf_en}, {8'h00, r1[7:0]});
    rd_chk(aet_pkg::ADDR_SEQCNT, total[15:0]);
    idle(1);
    rstn <= 1'b0;
    idle(3);
    rstn <= 1'b1;
    rd_chk(aet_pkg::ADDR_SEQCNT, 16'h0000);
    rd_chk(aet_pkg::ADDR_STATUS, 16'h0000);
    clr();
    pulse(8'h02);
    idle(10);
    ok(starts == 0);
    check({15'h0000, trig_overrun}, 16'h0000);
    end_of_test();
  end
endmodule

// ===== rtl/aet_pkg.sv
// constants and types shared by the adc external trigger control
// Contract
// - trigger off, continuous off: ignore trigger, one sequence after start, then stop.
// - trigger off, continuous on: ignore trigger, run sequences back to back.
// - edge mode: falling edge if polarity 0, rising if 1; one sequence per edge.
// - level mode: low active if polarity 0, high if 1; run while active.
// - in trigger modes the first conversion waits for the trigger, not configuration.
// - with trigger enabled, a start write only arms; conversion waits for trigger.
// - edge mode: an edge during a running sequence sets the overrun flag.
// - level mode: trigger drop and return during a sequence is no overrun.
// - level mode: trigger still active at sequence end starts the next at once.
// - per-pin enable gates each pad into the digital port register.
package aet_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NPINS = 8;
  localparam int SEQ_W = 8;
  localparam int CNT_W = 16;
  localparam int TRIG_PIN = 7;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_START = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_DIBE = 4'h3;
  localparam logic [3:0] ADDR_PORT = 4'h4;
  localparam logic [3:0] ADDR_SEQLEN = 4'h5;
  localparam logic [3:0] ADDR_SEQCNT = 4'h6;

  localparam int CTRL_ETRIG_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_LVL_BIT = 2;
  localparam int CTRL_SCAN_BIT = 3;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_OVR_BIT = 2;
  localparam int STAT_TRIG_BIT = 3;

  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] DIBE_RST = 8'h00;
  localparam logic [7:0] SEQLEN_RST = 8'h0F;
  localparam logic [15:0] SEQCNT_RST = 16'h0000;

  typedef enum logic [1:0]
  {
    AET_IDLE = 2'b00,
    AET_ARMED = 2'b01,
    AET_RUN = 2'b10
  } aet_state_type;

endpackage

// ===== rtl/aet_sync.sv
// two-flop synchroniser for pad levels
`timescale 1ns/1ps
module aet_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

// ===== rtl/aet_trigger_ctrl.sv
// conversion sequence start control with external trigger and digital input buffers
`timescale 1ns/1ps
module aet_trigger_ctrl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [7:0] pad_in,
  output logic [7:0] dig_buf_en,
  output logic conv_start,
  output logic conv_busy,
  output logic seq_done,
  output logic trig_overrun
);

  aet_pkg::aet_state_type state_reg;
  aet_pkg::aet_state_type state_next;
  logic [3:0] ctrl_reg;
  logic [7:0] dibe_reg;
  logic [7:0] port_reg;
  logic [7:0] seq_len_reg;
  logic [7:0] seq_cnt_reg;
  logic [7:0] seq_cnt_next;
  logic [15:0] seq_total_reg;
  logic ovr_reg;
  logic trig_prev_reg;
  logic conv_start_reg;
  logic conv_busy_reg;
  logic seq_done_reg;
  logic [15:0] rdata_reg;
  logic start_seq;

  wire [7:0] pad_sync;
  wire external_trigger_enable;
  wire trigger_polarity;
  wire trigger_level_select;
  wire scan_mode;
  wire sequence_start_control;
  wire ctrl_wr;
  wire dibe_wr;
  wire seqlen_wr;
  wire status_wr;
  wire ovr_clr;
  wire trig_raw;
  wire trig_act;
  wire trig_act_prev;
  wire trig_edge;
  wire trig_go;
  wire seq_last;
  wire in_run;
  wire ovr_set;
  wire [7:0] port_next;
  wire [15:0] status_word;
  wire [15:0] rd_mux;

  // pads are asynchronous to the bus clock
  aet_sync #(
    .WIDTH(aet_pkg::NPINS)
  ) u_pad_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .d(pad_in),
    .q(pad_sync)
  );

  assign external_trigger_enable = ctrl_reg[aet_pkg::CTRL_ETRIG_BIT];
  assign trigger_polarity = ctrl_reg[aet_pkg::CTRL_POL_BIT];
  assign trigger_level_select = ctrl_reg[aet_pkg::CTRL_LVL_BIT];
  assign scan_mode = ctrl_reg[aet_pkg::CTRL_SCAN_BIT];

  assign ctrl_wr = wr && (addr == aet_pkg::ADDR_CTRL);
  assign sequence_start_control = wr && (addr == aet_pkg::ADDR_START);
  assign status_wr = wr && (addr == aet_pkg::ADDR_STATUS);
  assign dibe_wr = wr && (addr == aet_pkg::ADDR_DIBE);
  assign seqlen_wr = wr && (addr == aet_pkg::ADDR_SEQLEN);
  assign ovr_clr = status_wr && wdata[aet_pkg::STAT_OVR_BIT];

  // buffer off reads as zero, so with trigger polarity 1 a disabled pad cannot fake a trigger; with polarity 0 it reads as active
  assign port_next = pad_sync & dibe_reg;
  assign trig_raw = port_next[aet_pkg::TRIG_PIN];
  assign trig_act = trigger_polarity ? trig_raw : ~trig_raw;
  assign trig_act_prev = trigger_polarity ? trig_prev_reg : ~trig_prev_reg;
  assign trig_edge = trig_act && !trig_act_prev;
  assign trig_go = trigger_level_select ? trig_act : trig_edge;

  assign in_run = (state_reg == aet_pkg::AET_RUN);
  assign seq_last = in_run && (seq_cnt_reg >= seq_len_reg);
  assign ovr_set = external_trigger_enable && !trigger_level_select && in_run && trig_edge;

  always_comb
  begin
    state_next = state_reg;
    start_seq = 1'b0;
    if (sequence_start_control)
    begin
      if (external_trigger_enable)
      begin
        state_next = aet_pkg::AET_ARMED;
      end
      else
      begin
        state_next = aet_pkg::AET_RUN;
        start_seq = 1'b1;
      end
    end
    else
    begin
      case (state_reg)
        aet_pkg::AET_IDLE:
        begin
          state_next = aet_pkg::AET_IDLE;
        end
        aet_pkg::AET_ARMED:
        begin
          if (!external_trigger_enable)
          begin
            state_next = aet_pkg::AET_IDLE;
          end
          else if (trig_go)
          begin
            state_next = aet_pkg::AET_RUN;
            start_seq = 1'b1;
          end
        end
        aet_pkg::AET_RUN:
        begin
          if (seq_last)
          begin
            if (external_trigger_enable)
            begin
              if (trigger_level_select && trig_act)
              begin
                start_seq = 1'b1;
              end
              else
              begin
                state_next = aet_pkg::AET_ARMED;
              end
            end
            else if (scan_mode)
            begin
              start_seq = 1'b1;
            end
            else
            begin
              state_next = aet_pkg::AET_IDLE;
            end
          end
        end
        default:
        begin
          state_next = aet_pkg::AET_IDLE;
        end
      endcase
    end
  end

  assign seq_cnt_next = start_seq ? 8'h00 : (in_run ? seq_cnt_reg + 8'h01 : seq_cnt_reg);

  assign status_word = {12'h000, trig_raw, ovr_reg, state_reg == aet_pkg::AET_ARMED, conv_busy_reg};
  assign rd_mux = (addr == aet_pkg::ADDR_CTRL) ? {12'h000, ctrl_reg} :
                  (addr == aet_pkg::ADDR_STATUS) ? status_word :
                  (addr == aet_pkg::ADDR_DIBE) ? {8'h00, dibe_reg} :
                  (addr == aet_pkg::ADDR_PORT) ? {8'h00, port_reg} :
                  (addr == aet_pkg::ADDR_SEQLEN) ? {8'h00, seq_len_reg} :
                  (addr == aet_pkg::ADDR_SEQCNT) ? seq_total_reg : 16'h0000;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ctrl_reg <= aet_pkg::CTRL_RST;
      dibe_reg <= aet_pkg::DIBE_RST;
      seq_len_reg <= aet_pkg::SEQLEN_RST;
      rdata_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (ctrl_wr)
        ctrl_reg <= wdata[3:0];
      if (dibe_wr)
        dibe_reg <= wdata[7:0];
      if (seqlen_wr)
        seq_len_reg <= wdata[7:0];
      rdata_reg <= rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_reg <= aet_pkg::AET_IDLE;
      seq_cnt_reg <= 8'h00;
      seq_total_reg <= aet_pkg::SEQCNT_RST;
      trig_prev_reg <= 1'b0;
      port_reg <= 8'h00;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      seq_cnt_reg <= seq_cnt_next;
      trig_prev_reg <= trig_raw;
      port_reg <= port_next;
      if (start_seq)
        seq_total_reg <= seq_total_reg + 16'h0001;
    end
  end

  // set wins over a simultaneous software clear
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ovr_reg <= 1'b0;
      conv_start_reg <= 1'b0;
      conv_busy_reg <= 1'b0;
      seq_done_reg <= 1'b0;
    end
    else if (ce)
    begin
      ovr_reg <= ovr_set | (ovr_reg & ~ovr_clr);
      conv_start_reg <= start_seq;
      conv_busy_reg <= (state_next == aet_pkg::AET_RUN);
      seq_done_reg <= seq_last && !sequence_start_control;
    end
  end

  assign rdata = rdata_reg;
  assign dig_buf_en = dibe_reg;
  assign conv_start = conv_start_reg;
  assign conv_busy = conv_busy_reg;
  assign seq_done = seq_done_reg;
  assign trig_overrun = ovr_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_single_stop: assert property (
    ce && seq_last && !external_trigger_enable && !scan_mode && !sequence_start_control
    |=> state_reg == aet_pkg::AET_IDLE && !conv_busy_reg && seq_done_reg)
    else $error("single sequence did not stop");

  a_scan_restart: assert property (
    ce && seq_last && !external_trigger_enable && scan_mode && !sequence_start_control
    |=> conv_start_reg && conv_busy_reg && seq_cnt_reg == 8'h00)
    else $error("continuous mode did not restart");

  a_edge_start: assert property (
    ce && state_reg == aet_pkg::AET_ARMED && external_trigger_enable && !trigger_level_select
    && trig_edge && !sequence_start_control
    |=> conv_start_reg && conv_busy_reg)
    else $error("edge did not start a sequence");

  a_level_start: assert property (
    ce && state_reg == aet_pkg::AET_ARMED && external_trigger_enable && trigger_level_select
    && trig_act && !sequence_start_control
    |=> conv_start_reg)
    else $error("active level did not start a sequence");

  a_wait_trigger: assert property (
    ce && state_reg == aet_pkg::AET_ARMED && !trig_go && !sequence_start_control
    |=> !conv_start_reg && !conv_busy_reg)
    else $error("conversion started without trigger");

  a_start_arms: assert property (
    ce && sequence_start_control && external_trigger_enable
    |=> state_reg == aet_pkg::AET_ARMED && !conv_start_reg && !conv_busy_reg)
    else $error("start write did not only arm");

  a_edge_overrun: assert property (
    ce && in_run && external_trigger_enable && !trigger_level_select && trig_edge
    |=> ovr_reg ##1 (ovr_reg || $past(ovr_clr)))
    else $error("overrun flag not set");

  a_level_no_ovr: assert property (
    ce && external_trigger_enable && trigger_level_select && !ovr_clr
    |=> ovr_reg == $past(ovr_reg))
    else $error("overrun changed in level mode");

  a_level_chain: assert property (
    ce && seq_last && external_trigger_enable && trigger_level_select && trig_act
    && !sequence_start_control
    |=> conv_start_reg && conv_busy_reg)
    else $error("level mode did not chain next sequence");

  a_port_gate: assert property (
    ce && dibe_reg == 8'h00 && !dibe_wr |=> port_reg == 8'h00)
    else $error("disabled buffer passed pad level");

  a_rdata_slot: assert property (
    ce && !rd |=> rdata_reg == 16'h0000)
    else $error("read data outside read slot");

  a_pad_sync: assert property (
    ce ##1 ce |=> pad_sync == $past(pad_in, 2))
    else $error("pad synchroniser delay wrong");

  a_idle_ignore: assert property (
    ce && state_reg == aet_pkg::AET_IDLE && !sequence_start_control
    |=> state_reg == aet_pkg::AET_IDLE && !conv_start_reg)
    else $error("idle converter reacted to trigger");

  a_edge_no_queue: assert property (
    ce && in_run && external_trigger_enable && !trigger_level_select && !seq_last && !sequence_start_control
    |=> !conv_start_reg)
    else $error("edge during sequence was queued");

  a_level_no_restart: assert property (
    ce && in_run && external_trigger_enable && trigger_level_select && !seq_last && !sequence_start_control
    |=> !conv_start_reg)
    else $error("level return restarted a running sequence");

  a_ovr_set_wins: assert property (
    ce && ovr_set && ovr_clr |=> ovr_reg)
    else $error("overrun clear beat a new overrun");

  a_armed_hold: assert property (
    ce && state_reg == aet_pkg::AET_ARMED && external_trigger_enable && !trig_go && !sequence_start_control
    |=> state_reg == aet_pkg::AET_ARMED)
    else $error("armed state left without trigger");

  a_ce_freeze: assert property (
    !ce |=> $stable(state_reg) && $stable(ctrl_reg) && $stable(ovr_reg) && $stable(seq_cnt_reg))
    else $error("state moved while clock enable low");

  c_edge_run: cover property (
    ce && state_reg == aet_pkg::AET_ARMED && trig_edge ##1 conv_start_reg);

  c_level_chain: cover property (
    seq_last && trigger_level_select && trig_act ##1 conv_start_reg);

  c_overrun: cover property (
    ovr_set ##1 ovr_reg);

  c_scan_restart: cover property (
    seq_last && scan_mode && !external_trigger_enable ##1 conv_start_reg);

endmodule
